// *** design/drr_top.sv ***
`timescale 1ns/1ps
// What this block does
// - transfer error sets error, global; disables channel
// - global clear never masks simultaneous error
// - half, done, error flags each clearable
// - sync overrun flag, write-one clear
// - other channel clear never loses overrun
// - trigger issues count field plus one requests
// - trigger before burst served sets overrun
// - trigger overrun flag, write-one clear
// - other generator clear never loses overrun
// - config holds select, sync select, enable, polarity
// - new selection routes only new request
module drr_top (
  input  wire logic                        i_clk_sys,   // 250 mhz system clock
  input  wire logic                        i_nrst,      // sync reset, low active
  input  wire logic                        i_wb_cyc,    // wishbone cycle
  input  wire logic                        i_wb_stb,    // wishbone strobe
  input  wire logic                        i_wb_we,     // write enable
  input  wire logic [7:0]                  i_wb_adr,    // byte address
  input  wire logic [3:0]                  i_wb_sel,    // byte selects
  input  wire logic [31:0]                 i_wb_dat,    // write data
  output logic      [31:0]                 o_wb_dat,    // read data
  output logic                             o_wb_ack,    // ack, one cycle
  input  wire logic [drr_pkg::N_REQ-1:0]   i_per_req,   // peripheral requests (pins)
  input  wire logic [drr_pkg::N_SYNC-1:0]  i_sync,      // sync / trigger inputs (pins)
  input  wire logic [drr_pkg::N_CH-1:0]    i_dma_ack,   // dma served one request
  input  wire drr_pkg::drr_dma_evt_type    i_dma_evt,   // dma channel events
  output logic      [drr_pkg::N_CH-1:0]    o_dma_req,   // routed requests
  output logic      [drr_pkg::N_CH-1:0]    o_dma_en,    // channel enables
  output logic                             o_irq        // level interrupt
);
  import drr_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [N_REQ-1:0]  req_s1, req_s2;          // request sync stages
  logic [N_SYNC-1:0] syn_s1, syn_s2, syn_d;   // sync stages and delay
  // first stage only feeds second stage
  always_ff @(posedge i_clk_sys) begin
    req_s1 <= i_per_req;
    req_s2 <= req_s1;
    syn_s1 <= i_sync;
    syn_s2 <= syn_s1;
    syn_d  <= syn_s2;
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic        acc, wr;                       // access, write strobe
  logic [31:0] wmask;                         // byte-lane mask
  assign acc   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr    = acc & i_wb_we;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  drr_cfg_type      cfg [N_CH];               // router channel config
  drr_cfg_type      next_cfg [N_CH];
  logic [5:0]       act_sel [N_CH];           // selection used for routing
  logic [5:0]       next_act_sel [N_CH];
  logic [4:0]       gcnt [N_GEN];             // req_count_minus_one
  logic [4:0]       next_gcnt [N_GEN];
  logic [1:0]       gpol [N_GEN];             // trigger polarity
  logic [1:0]       next_gpol [N_GEN];
  logic [N_GEN-1:0] gen_en, next_gen_en;      // generator enable
  logic [5:0]       left [N_GEN];             // requests still to serve
  logic [5:0]       next_left [N_GEN];
  logic [N_CH-1:0]  sync_overrun_flag, next_sof;
  logic [N_GEN-1:0] trig_overrun_flag, next_tof;
  logic [N_CH-1:0]  chan_global_flag, chan_xfer_done_flag;
  logic [N_CH-1:0]  chan_half_xfer_flag, chan_xfer_err_flag;
  logic [N_CH-1:0]  next_glb, next_tc, next_ht, next_te;
  logic [N_CH-1:0]  next_en;                  // dma enables
  logic [N_CH-1:0]  gate, next_gate;          // sync gate open
  logic [N_CH-1:0]  next_req;
  logic [15:0]      imask, next_imask;        // interrupt mask
  logic [31:0]      next_rdat;
  logic             next_irq;

  // ------------------------------------------------------------
  // event detection helpers
  // ------------------------------------------------------------
  // edge of a synchronised input per polarity code
  function automatic logic edge_hit(input logic [1:0] pol, input logic cur, input logic prv);
    edge_hit = (pol[0] & cur & ~prv) | (pol[1] & ~cur & prv);
  endfunction : edge_hit

  // register image of one router channel config; the struct packs its
  // fields tightly, the bus word keeps them at their documented positions
  function automatic logic [31:0] cfg_word(input drr_cfg_type c);
    cfg_word = (32'(c.request_select) << CFG_SEL_LSB)
             | (32'(c.sync_input_select) << CFG_SYNC_LSB)
             | (32'(c.sync_enable) << CFG_SE_BIT)
             | (32'(c.sync_edge_polarity) << CFG_POL_LSB);
  endfunction : cfg_word

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic sev;                                // sync event this cycle
    logic tev;                                // trigger event this cycle
    logic [31:0] w;                           // merged write value
    sev = 1'b0;
    tev = 1'b0;
    w   = 32'h0;
    next_sof   = sync_overrun_flag;
    next_tof   = trig_overrun_flag;
    next_glb   = chan_global_flag;
    next_tc    = chan_xfer_done_flag;
    next_ht    = chan_half_xfer_flag;
    next_te    = chan_xfer_err_flag;
    next_en    = o_dma_en;
    next_gen_en = gen_en;
    next_imask = imask;
    next_gate  = gate;
    next_rdat  = 32'h0;
    for (int c = 0; c < N_CH; c++) begin
      next_cfg[c]     = cfg[c];
      next_act_sel[c] = act_sel[c];
      next_req[c]     = 1'b0;
    end
    for (int g = 0; g < N_GEN; g++) begin
      next_gcnt[g] = gcnt[g];
      next_gpol[g] = gpol[g];
      next_left[g] = left[g];
    end
    // ---- software writes: clears first, hardware sets win after
    if (wr) begin
      for (int c = 0; c < N_CH; c++) begin
        if (i_wb_adr == OFF_CFG0 + 8'(4 * c)) begin
          w = (cfg_word(cfg[c]) & ~wmask) | (i_wb_dat & wmask);
          next_cfg[c].request_select     = w[CFG_SEL_LSB +: 6];
          next_cfg[c].sync_input_select  = w[CFG_SYNC_LSB +: 5];
          next_cfg[c].sync_enable        = w[CFG_SE_BIT];
          next_cfg[c].sync_edge_polarity = w[CFG_POL_LSB +: 2];
          // new selection takes effect at once
          next_act_sel[c] = w[CFG_SEL_LSB +: 6];
        end
      end
      for (int g = 0; g < N_GEN; g++) begin
        if (i_wb_adr == OFF_GCFG0 + 8'(4 * g)) begin
          w = ({15'h0, gen_en[g], 3'h0, gcnt[g], 6'h0, gpol[g]} & ~wmask) | (i_wb_dat & wmask);
          next_gpol[g]   = w[1:0];
          next_gcnt[g]   = w[GCFG_CNT_LSB +: 5];
          next_gen_en[g] = w[GCFG_EN_BIT];
        end
      end
      if (i_wb_adr == OFF_CCLR)  next_sof = sync_overrun_flag & ~i_wb_dat[N_CH-1:0];
      if (i_wb_adr == OFF_GCLR)  next_tof = trig_overrun_flag & ~i_wb_dat[N_GEN-1:0];
      if (i_wb_adr == OFF_DCLR) begin
        for (int c = 0; c < N_CH; c++) begin
          if (i_wb_dat[4*c + DF_GLB]) next_glb[c] = 1'b0;
          if (i_wb_dat[4*c + DF_TC])  next_tc[c]  = 1'b0;
          if (i_wb_dat[4*c + DF_HT])  next_ht[c]  = 1'b0;
          if (i_wb_dat[4*c + DF_TE])  next_te[c]  = 1'b0;
        end
      end
      if (i_wb_adr == OFF_DEN)   next_en    = i_wb_dat[N_CH-1:0];
      if (i_wb_adr == OFF_IMASK) next_imask = i_wb_dat[15:0];
    end
    // ---- dma channel events
    for (int c = 0; c < N_CH; c++) begin
      if (i_dma_evt.half[c]) begin next_ht[c] = 1'b1; next_glb[c] = 1'b1; end
      if (i_dma_evt.done[c]) begin next_tc[c] = 1'b1; next_glb[c] = 1'b1; end
      // error sets both flags and disables, beats any clear
      if (i_dma_evt.err[c]) begin
        next_te[c]  = 1'b1;
        next_glb[c] = 1'b1;
        next_en[c]  = 1'b0;
      end
    end
    // ---- router channels with synchronisation
    for (int c = 0; c < N_CH; c++) begin
      sev = edge_hit(cfg[c].sync_edge_polarity,
                     syn_s2[cfg[c].sync_input_select[1:0]],
                     syn_d[cfg[c].sync_input_select[1:0]]);
      if (!cfg[c].sync_enable) begin
        next_gate[c] = 1'b1;
      end else if (sev) begin
        // overrun sets regardless of clear writes
        if (gate[c]) next_sof[c] = 1'b1;
        next_gate[c] = 1'b1;
      end else if (i_dma_ack[c]) begin
        next_gate[c] = 1'b0;
      end
      if (act_sel[c] < 6'(N_REQ)) begin
        next_req[c] = req_s2[act_sel[c][2:0]] & gate[c] & o_dma_en[c];
      end
      if (act_sel[c] >= 6'(N_REQ) && act_sel[c] < 6'(N_REQ + N_GEN)) begin
        next_req[c] = (left[act_sel[c][1:0]] != 6'h0) & gate[c] & o_dma_en[c];
      end
    end
    // ---- request generators
    for (int g = 0; g < N_GEN; g++) begin
      tev = gen_en[g] & edge_hit(gpol[g], syn_s2[g], syn_d[g]);
      for (int c = 0; c < N_CH; c++) begin
        if (act_sel[c] == 6'(N_REQ + g) && i_dma_ack[c] && left[g] != 6'h0) begin
          next_left[g] = left[g] - 6'h1;
        end
      end
      if (tev) begin
        // overrun while any request pending, final cycle too
        if (left[g] != 6'h0) begin
          next_tof[g] = 1'b1;
        end else begin
          next_left[g] = {1'b0, gcnt[g]} + 6'h1;
        end
      end
      if (!gen_en[g]) next_left[g] = 6'h0;
    end
    // ---- read mux
    for (int c = 0; c < N_CH; c++) begin
      if (i_wb_adr == OFF_CFG0 + 8'(4 * c)) next_rdat = cfg_word(cfg[c]);
    end
    for (int g = 0; g < N_GEN; g++) begin
      if (i_wb_adr == OFF_GCFG0 + 8'(4 * g))
        next_rdat = {15'h0, gen_en[g], 3'h0, gcnt[g], 6'h0, gpol[g]};
    end
    case (i_wb_adr)
      OFF_CSTAT: next_rdat = {28'h0, sync_overrun_flag};
      OFF_GSTAT: next_rdat = {28'h0, trig_overrun_flag};
      OFF_DSTAT: begin
        for (int c = 0; c < N_CH; c++) begin
          next_rdat[4*c +: 4] = {chan_xfer_err_flag[c], chan_half_xfer_flag[c],
                                 chan_xfer_done_flag[c], chan_global_flag[c]};
        end
      end
      OFF_DEN:   next_rdat = {28'h0, o_dma_en};
      OFF_IMASK: next_rdat = {16'h0, imask};
      default:   next_rdat = next_rdat;   // unmapped reads zero
    endcase
    // ---- interrupt: overruns, dma errors and dma global flags
    next_irq = |({next_tof, next_sof, next_te, next_glb} & next_imask);
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      for (int c = 0; c < N_CH; c++) begin
        cfg[c]     <= drr_cfg_type'(RST_VAL[13:0]);
        act_sel[c] <= 6'h0;
      end
      for (int g = 0; g < N_GEN; g++) begin
        gcnt[g] <= 5'h0;
        gpol[g] <= 2'h0;
        left[g] <= 6'h0;
      end
      gen_en              <= '0;
      sync_overrun_flag   <= '0;
      trig_overrun_flag   <= '0;
      chan_global_flag    <= '0;
      chan_xfer_done_flag <= '0;
      chan_half_xfer_flag <= '0;
      chan_xfer_err_flag  <= '0;
      o_dma_en            <= '0;
      gate                <= '0;
      o_dma_req           <= '0;
      imask               <= 16'h0;
      o_wb_dat            <= 32'h0;
      o_wb_ack            <= 1'b0;
      o_irq               <= 1'b0;
    end else begin
      cfg                 <= next_cfg;
      act_sel             <= next_act_sel;
      gcnt                <= next_gcnt;
      gpol                <= next_gpol;
      left                <= next_left;
      gen_en              <= next_gen_en;
      sync_overrun_flag   <= next_sof;
      trig_overrun_flag   <= next_tof;
      chan_global_flag    <= next_glb;
      chan_xfer_done_flag <= next_tc;
      chan_half_xfer_flag <= next_ht;
      chan_xfer_err_flag  <= next_te;
      o_dma_en            <= next_en;
      gate                <= next_gate;
      o_dma_req           <= next_req;
      imask               <= next_imask;
      o_wb_dat            <= (acc & ~i_wb_we) ? next_rdat : 32'h0;
      o_wb_ack            <= acc;
      o_irq               <= next_irq;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_err_disables: assert property (i_dma_evt.err[0] |=> !o_dma_en[0] && chan_xfer_err_flag[0])
    else $error("error did not disable channel");
  a_err_over_clr: assert property (i_dma_evt.err[1] && wr && i_wb_adr == OFF_DCLR
      |=> chan_global_flag[1] && chan_xfer_err_flag[1])
    else $error("clear masked error");
  a_tof_set_wins: assert property (gen_en[1] && left[1] != 6'h0
      && edge_hit(gpol[1], syn_s2[1], syn_d[1]) |=> trig_overrun_flag[1])
    else $error("trigger overrun lost");
  a_sof_set_wins: assert property (cfg[2].sync_enable && gate[2]
      && edge_hit(cfg[2].sync_edge_polarity, syn_s2[cfg[2].sync_input_select[1:0]],
                  syn_d[cfg[2].sync_input_select[1:0]]) |=> sync_overrun_flag[2])
    else $error("sync overrun lost");
  a_burst_len: assert property (gen_en[0] && left[0] == 6'h0
      && edge_hit(gpol[0], syn_s2[0], syn_d[0]) |=> left[0] == $past({1'b0, gcnt[0]}) + 6'h1)
    else $error("wrong burst length");
  a_ack_one: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  c_err:  cover property (i_dma_evt.err[0] ##1 !o_dma_en[0]);
  c_sof:  cover property ($rose(sync_overrun_flag[2]));
  c_tof:  cover property ($rose(trig_overrun_flag[1]));
endmodule : drr_top

// *** design/drr_pkg.sv ***
package drr_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int N_CH   = 4;                  // router / dma channels
  localparam int N_GEN  = 4;                  // request generators
  localparam int N_REQ  = 8;                  // peripheral request inputs
  localparam int N_SYNC = 4;                  // sync / trigger inputs
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CFG0    = 8'h00; // router_chan_config_reg, 4 words
  localparam logic [7:0] OFF_CSTAT   = 8'h10; // router_chan_status_reg
  localparam logic [7:0] OFF_CCLR    = 8'h14; // router_chan_clear_reg
  localparam logic [7:0] OFF_GCFG0   = 8'h20; // generator config, 4 words
  localparam logic [7:0] OFF_GSTAT   = 8'h30; // generator_status_reg
  localparam logic [7:0] OFF_GCLR    = 8'h34; // generator_clear_reg
  localparam logic [7:0] OFF_DSTAT   = 8'h40; // dma flags
  localparam logic [7:0] OFF_DCLR    = 8'h44; // dma_flag_clear_reg
  localparam logic [7:0] OFF_DEN     = 8'h48; // dma channel enables
  localparam logic [7:0] OFF_IMASK   = 8'h4c; // interrupt mask
  // ------------------------------------------------------------
  // field positions of router_chan_config_reg and generator config
  // ------------------------------------------------------------
  localparam int CFG_SEL_LSB  = 0;            // request_select [5:0]
  localparam int CFG_SYNC_LSB = 8;            // sync_input_select [4:0]
  localparam int CFG_SE_BIT   = 16;           // sync_enable
  localparam int CFG_POL_LSB  = 17;           // sync_edge_polarity [1:0]
  localparam int GCFG_CNT_LSB = 8;            // req_count_minus_one [4:0]
  localparam int GCFG_EN_BIT  = 16;           // generator enable
  // dma flag layout per channel: global, done, half, error
  localparam int DF_GLB = 0;
  localparam int DF_TC  = 1;
  localparam int DF_HT  = 2;
  localparam int DF_TE  = 3;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  // ------------------------------------------------------------
  // packed carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync_edge_polarity;           // 00 none, 01 rise, 10 fall, 11 both
    logic       sync_enable;
    logic [4:0] sync_input_select;
    logic [5:0] request_select;
  } drr_cfg_type;
  typedef struct packed {
    logic [N_CH-1:0] done;                    // transfer complete
    logic [N_CH-1:0] half;                    // half transfer
    logic [N_CH-1:0] err;                     // transfer error
  } drr_dma_evt_type;
endpackage : drr_pkg

// *** sim/drr_dma_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// dma controller stand-in: serves routed requests
// ------------------------------------------------------------
module drr_dma_model (
  input  wire logic       i_clk_sys, // system clock
  input  wire logic       i_nrst,    // sync reset, low active
  input  wire logic [3:0] i_req,     // routed request levels
  input  wire logic       i_stall,   // hold off all service
  input  wire logic [3:0] i_delay,   // wait cycles before serving
  output logic      [3:0] o_ack      // one-cycle served pulse
);
  logic [3:0] wait_cnt [4];          // per channel service timer

  // serve one request per channel after the set delay;
  // the timer restarts after each pulse so a request level that
  // is still falling is never served twice (delay of 2 or more)
  always_ff @(posedge i_clk_sys) begin
    for (int c = 0; c < 4; c++) begin
      if (!i_nrst || i_stall || !i_req[c]) begin
        o_ack[c]    <= 1'b0;
        wait_cnt[c] <= 4'h0;
      end else if (wait_cnt[c] == i_delay) begin
        o_ack[c]    <= 1'b1;
        wait_cnt[c] <= 4'h0;
      end else begin
        o_ack[c]    <= 1'b0;
        wait_cnt[c] <= wait_cnt[c] + 4'h1;
      end
    end
  end
endmodule : drr_dma_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import drr_pkg::*;
  // ------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------
  logic              clk, nrst, cyc, stb, we, ack, irq, stall;
  logic [7:0]        adr;            // wishbone address
  logic [3:0]        sel;            // byte lanes
  logic [31:0]       wdat, rdat, q;  // write, read, last read
  logic [N_REQ-1:0]  per_req;        // peripheral requests
  logic [N_SYNC-1:0] sync;           // sync / trigger pins
  logic [N_CH-1:0]   dack, dreq, den;
  drr_dma_evt_type   evt;            // dma event pulses
  int                mismatches, samples_checked, acks1, cycles;
  int                base;           // channel 1 service count at burst start
  int                cycles_tbl [4] = '{0, 1, 3, 7}; // burst sizes minus one

  drr_top dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_per_req(per_req), .i_sync(sync), .i_dma_ack(dack),
    .i_dma_evt(evt), .o_dma_req(dreq), .o_dma_en(den), .o_irq(irq));
  drr_dma_model model_u (.i_clk_sys(clk), .i_nrst(nrst), .i_req(dreq),
    .i_stall(stall), .i_delay(4'h3), .o_ack(dack));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // cycle count, channel 1 service count, hang guard
  always @(posedge clk) begin
    cycles++;
    if (dack[1] === 1'b1) acks1++;
    if (cycles == 5000) begin
      mismatches++;
      $display("[ERR] timeout expected done got hang");
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // classic cycle: hold until ack, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 40) chk("wb ack", 32'h1, 32'h0);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  function automatic logic [31:0] cfgw(int s, int ss, logic se, logic [1:0] p);
    return (32'(s) << CFG_SEL_LSB) | (32'(ss) << CFG_SYNC_LSB) |
           (32'(se) << CFG_SE_BIT) | (32'(p) << CFG_POL_LSB);
  endfunction : cfgw
  // generator: count minus one, enabled, rising trigger
  function automatic logic [31:0] gcfgw(int n);
    return (32'(n) << GCFG_CNT_LSB) | (32'h1 << GCFG_EN_BIT) | 32'h1;
  endfunction : gcfgw
  // overrun on pin b while another bit is being cleared, at
  // several offsets so one lands on the clear write itself
  task automatic ovr(input logic [7:0] st, input logic [7:0] cl, input int b, input string nm);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) sync[b] <= 1'b1;
      repeat (k) @(posedge clk);
      wr(cl, 32'h1);
      repeat (4) @(posedge clk);
      wb(1'b0, st, 32'h0);
      chk(nm, 32'h1 << b, q & (32'h1 << b));
      wr(cl, 32'h1 << b);
      sync[b] <= 1'b0;
      wb(1'b0, st, 32'h0);
      chk(nm, 32'h0, q & (32'h1 << b));
      repeat (3) @(posedge clk);
    end
  endtask : ovr
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hf;
    wdat = 32'h0; per_req = '0; sync = '0; evt = '0; stall = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(OFF_DSTAT, RST_VAL, "dma flags");
    rd(OFF_CSTAT, RST_VAL, "sync overrun");
    rd(OFF_GSTAT, RST_VAL, "trig overrun");
    rd(8'h80, 32'h0, "unmapped");
    // one event kind per channel: error, half, done
    wr(OFF_DEN, 32'hf);
    @(posedge clk) evt <= '{done: 4'h4, half: 4'h2, err: 4'h1};
    @(posedge clk) evt <= '0;
    repeat (3) @(posedge clk);
    rd(OFF_DSTAT, 32'h0000_0359, "dma flags");
    chk("dma enables", 32'he, 32'(den));
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFF_IMASK, 32'h10);
    repeat (2) @(posedge clk);
    chk("irq set", 32'h1, 32'(irq));
    wr(OFF_DCLR, 32'h359);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, 32'(irq));
    rd(OFF_DSTAT, 32'h0, "dma flags");
    // error on channel 1 in the cycle its global clear lands
    wr(OFF_DEN, 32'hf);
    fork
      wr(OFF_DCLR, 32'h10);
      begin
        @(posedge clk) evt.err <= 4'h2;
        @(posedge clk) evt.err <= 4'h0;
      end
    join
    repeat (3) @(posedge clk);
    rd(OFF_DSTAT, 32'h90, "dma flags");
    chk("dma enables", 32'hd, 32'(den));
    // routing follows a changed selection only
    wr(OFF_CFG0, cfgw(3, 0, 1'b0, 2'b00));
    rd(OFF_CFG0, 32'h3, "config");
    per_req <= 8'h08;
    repeat (8) @(posedge clk);
    chk("route old", 32'h1, 32'(dreq[0]));
    sync[0] <= 1'b1;
    repeat (2) @(posedge clk);
    wr(OFF_CFG0, cfgw(5, 0, 1'b0, 2'b00));
    sync[0] <= 1'b0;
    repeat (8) @(posedge clk);
    chk("route new", 32'h0, 32'(dreq[0]));
    per_req <= 8'h20;
    repeat (8) @(posedge clk);
    chk("route new", 32'h1, 32'(dreq[0]));
    per_req <= '0;
    // generator 0 on channel 1, burst lengths; channel 1 was
    // disabled by its error above, so enable it again first
    wr(OFF_DEN, 32'hf);
    wr(OFF_CFG0 + 8'h04, cfgw(8, 0, 1'b0, 2'b00));
    foreach (cycles_tbl[i]) begin
      wr(OFF_GCFG0, gcfgw(cycles_tbl[i]));
      base = acks1;
      @(posedge clk) sync[0] <= 1'b1;
      repeat (80) @(posedge clk);
      sync[0] <= 1'b0;
      chk("burst length", 32'(cycles_tbl[i] + 1), 32'(acks1 - base));
    end
    rd(OFF_GSTAT, 32'h0, "trig overrun");
    // overruns with service stalled
    stall <= 1'b1;
    wr(OFF_CFG0 + 8'h0c, cfgw(9, 0, 1'b0, 2'b00));
    wr(OFF_GCFG0 + 8'h04, gcfgw(1));
    @(posedge clk) sync[1] <= 1'b1;
    repeat (4) @(posedge clk);
    sync[1] <= 1'b0;
    wr(OFF_GCLR, 32'hf);
    ovr(OFF_GSTAT, OFF_GCLR, 1, "trig overrun");
    wr(OFF_CFG0 + 8'h08, cfgw(2, 2, 1'b0, 2'b00));
    wr(OFF_CFG0 + 8'h08, cfgw(2, 2, 1'b1, 2'b01));
    per_req <= 8'h04;
    @(posedge clk) sync[2] <= 1'b1;
    repeat (4) @(posedge clk);
    sync[2] <= 1'b0;
    wr(OFF_CCLR, 32'hf);
    ovr(OFF_CSTAT, OFF_CCLR, 2, "sync overrun");
    stall <= 1'b0;
    finish_test();
  end
endmodule : testbench
